/* File: rtl/smsirq_params.svh */
// constants for the slave interrupt logic of the message handshake mode
`ifndef SMSIRQ_PARAMS_SVH
`define SMSIRQ_PARAMS_SVH
`define SMSIRQ_ADDR_W 4
`define SMSIRQ_OFS_SOURCE 4'h0
`define SMSIRQ_OFS_ENABLE 4'h1
`define SMSIRQ_OFS_FLAG 4'h2
`define SMSIRQ_OFS_HOSTCTL 4'h3
`define SMSIRQ_BIT_XFER_START 0
`define SMSIRQ_BIT_CTRL_SENT 1
`define SMSIRQ_BIT_STATUS_TAKEN 2
`define SMSIRQ_BIT_DATA_TAKEN 3
`define SMSIRQ_BIT_DATA_SENT 4
`define SMSIRQ_BIT_BUSY 0
`define SMSIRQ_BIT_GLOBAL_EN 0
`define SMSIRQ_NUM_SRC 5
`define SMSIRQ_RST_ENABLE 8'h00
`define SMSIRQ_RST_SOURCE 8'h00
`endif

/* File: rtl/smsirq_pkg.sv */
// types for the slave interrupt logic of the message handshake mode
package smsirq_pkg;
    typedef struct packed {
        logic [3:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } smsirq_bus_s;
    typedef struct packed {
        logic busy_set;
        logic data_reg_write;
        logic write_cycle;
        logic data_reg_read;
        logic status_read;
        logic ctrl_write;
    } smsirq_host_s;
endpackage : smsirq_pkg

/* File: rtl/smsirq_top.sv */
// slave interrupt flags, enables and shared interrupt of the message handshake mode
// Operation
// [RULE1] busy rising edge sets transfer-start flag
// [RULE2] transfer-start interrupts only with both enables
// [RULE3] flag clears by zero write after read-one
// [RULE4] software only clears flags, never sets
// [RULE5] global enable gates the shared interrupt
// [RULE6] enable bits seven-five reserved, reset zero
// [RULE7] enable bit four gates data-sent flag
// [RULE8] enable bit three gates data-taken flag
// [RULE9] enable bit two gates status-taken flag
// [RULE10] enable bit one gates ctrl-sent flag
// [RULE11] enable bit zero gates transfer-start flag
// [RULE12] enable register is slave only
// [RULE13] host sets busy, slave clears after read
// [RULE14] host data write in write cycle sets
// [RULE15] interrupt is global AND of gated sources
//
// Chosen here: the strobed register port and the register offsets.
`timescale 1ns/100ps
`include "smsirq_params.svh"
module smsirq_top (
    // clock and reset
    input wire logic clk_in,
    input wire logic nrst_in,
    // slave register port
    input wire smsirq_pkg::smsirq_bus_s bus_in,
    output logic [7:0] rdata_out,
    // host-side events
    input wire smsirq_pkg::smsirq_host_s host_in,
    // shared slave interrupt
    output logic host_ibuf_slave_irq_out
);
    import smsirq_pkg::*;

    localparam int NSRC = `SMSIRQ_NUM_SRC;

    logic [7:0] enable_reg;
    logic [NSRC-1:0] source_reg;
    logic [NSRC-1:0] armed_reg;
    logic busy_reg;
    logic busy_armed_reg;
    logic busy_prev_reg;
    logic global_en_reg;
    logic [7:0] rdata_reg;
    logic irq_reg;

    wire sel_source = bus_in.addr == `SMSIRQ_OFS_SOURCE;
    wire sel_enable = bus_in.addr == `SMSIRQ_OFS_ENABLE;
    wire sel_flag = bus_in.addr == `SMSIRQ_OFS_FLAG;
    wire sel_hostctl = bus_in.addr == `SMSIRQ_OFS_HOSTCTL;
    wire wr_source = bus_in.wr && sel_source;
    wire rd_source = bus_in.rd && sel_source;
    wire wr_flag = bus_in.wr && sel_flag;
    wire rd_flag = bus_in.rd && sel_flag;
    wire wr_enable = bus_in.wr && sel_enable;
    wire wr_hostctl = bus_in.wr && sel_hostctl;

    // rising edge of busy starts a transfer
    wire busy_rise = busy_reg && !busy_prev_reg; // RULE1
    // busy: host write of one sets, slave zero write after read-one clears
    wire busy_clr = wr_flag && !bus_in.wdata[`SMSIRQ_BIT_BUSY] && busy_armed_reg; // RULE13
    wire busy_next = host_in.busy_set || (busy_reg && !busy_clr); // RULE13
    // a read that sees busy set arms the clear; a host set still wins over the clear
    wire busy_armed_next = busy_next &&
        ((rd_flag && busy_reg) || (busy_armed_reg && !busy_clr)); // RULE13

    wire [NSRC-1:0] src_set;
    assign src_set[`SMSIRQ_BIT_XFER_START] = busy_rise; // RULE1
    assign src_set[`SMSIRQ_BIT_CTRL_SENT] = host_in.ctrl_write;
    assign src_set[`SMSIRQ_BIT_STATUS_TAKEN] = host_in.status_read;
    assign src_set[`SMSIRQ_BIT_DATA_TAKEN] = host_in.data_reg_read && !host_in.write_cycle;
    assign src_set[`SMSIRQ_BIT_DATA_SENT] = host_in.data_reg_write && host_in.write_cycle; // RULE14

    logic [NSRC-1:0] source_next;
    logic [NSRC-1:0] armed_next;
    genvar gi;
    generate
        for (gi = 0; gi < NSRC; gi++) begin : g_src
            // a zero written counts only once the slave has seen the flag set
            wire clr = wr_source && !bus_in.wdata[gi] && armed_reg[gi]; // RULE3
            // set beats clear; a written one has no effect
            assign source_next[gi] = src_set[gi] || (source_reg[gi] && !clr); // RULE4
            assign armed_next[gi] = source_next[gi] &&
                ((rd_source && source_reg[gi]) || (armed_reg[gi] && !clr)); // RULE3
        end
    endgenerate

    // per-source gating then global enable
    wire [NSRC-1:0] gated = source_next & enable_reg[NSRC-1:0]; // RULE7 RULE8 RULE9 RULE10 RULE11
    wire irq_next = global_en_reg && (|gated); // RULE2 RULE5 RULE15

    wire [7:0] rd_mux =
        sel_source ? {{(8-NSRC){1'b0}}, source_reg} :
        sel_enable ? enable_reg : // RULE12
        sel_flag ? {7'h00, busy_reg} :
        sel_hostctl ? {7'h00, global_en_reg} : 8'h00;

    // all eight enable bits are plain storage; the host has no path to them
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            enable_reg <= `SMSIRQ_RST_ENABLE; // RULE6
        end else if (wr_enable) begin
            enable_reg <= bus_in.wdata; // RULE6 RULE12
        end
    end

    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            global_en_reg <= 1'b0;
        end else if (wr_hostctl) begin
            global_en_reg <= bus_in.wdata[`SMSIRQ_BIT_GLOBAL_EN]; // RULE5
        end
    end

    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            source_reg <= NSRC'(`SMSIRQ_RST_SOURCE);
            armed_reg <= '0;
        end else begin
            source_reg <= source_next; // RULE1 RULE14
            armed_reg <= armed_next; // RULE3
        end
    end

    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            busy_reg <= 1'b0;
            busy_prev_reg <= 1'b0;
            busy_armed_reg <= 1'b0;
        end else begin
            busy_reg <= busy_next; // RULE13
            busy_prev_reg <= busy_reg; // RULE1
            busy_armed_reg <= busy_armed_next; // RULE13
        end
    end

    // read data are zero outside the cycle after a read strobe
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            rdata_reg <= 8'h00;
        end else begin
            rdata_reg <= bus_in.rd ? rd_mux : 8'h00;
        end
    end

    // registered so the interrupt pin comes straight from a flip-flop
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            irq_reg <= 1'b0;
        end else begin
            irq_reg <= irq_next; // RULE15
        end
    end

    assign rdata_out = rdata_reg;
    assign host_ibuf_slave_irq_out = irq_reg;

    // checks
    a_busy_edge_sets: assert property ( // RULE1
        @(posedge clk_in) disable iff (!nrst_in)
        busy_reg && !$past(busy_reg)
        |=> source_reg[`SMSIRQ_BIT_XFER_START])
        else $error("busy rise did not set transfer-start flag");

    a_irq_needs_global: assert property ( // RULE5
        @(posedge clk_in) disable iff (!nrst_in)
        !global_en_reg
        |=> !host_ibuf_slave_irq_out)
        else $error("interrupt without global enable");

    a_xfer_irq_gate: assert property ( // RULE2
        @(posedge clk_in) disable iff (!nrst_in)
        source_next == 5'h01 && enable_reg[0] && global_en_reg
        |=> host_ibuf_slave_irq_out)
        else $error("transfer-start interrupt missing");

    a_clear_needs_read: assert property ( // RULE3
        @(posedge clk_in) disable iff (!nrst_in)
        source_reg[0] && !armed_reg[0] && !busy_rise
        |=> source_reg[0])
        else $error("flag cleared without prior read");

    a_clear_after_read: assert property ( // RULE3
        @(posedge clk_in) disable iff (!nrst_in)
        armed_reg[0] && wr_source && !bus_in.wdata[0] && !busy_rise
        |=> !source_reg[0])
        else $error("flag not cleared after read and zero write");

    a_armed_after_read: assert property ( // RULE3
        @(posedge clk_in) disable iff (!nrst_in)
        !armed_reg[0] && !(rd_source && source_reg[0])
        |=> !armed_reg[0])
        else $error("clear armed without a read of the set flag");

    a_source_readback: assert property ( // RULE3
        @(posedge clk_in) disable iff (!nrst_in)
        rd_source
        |=> rdata_out == 8'($past(source_reg)))
        else $error("source read data wrong");

    a_one_never_sets: assert property ( // RULE4
        @(posedge clk_in) disable iff (!nrst_in)
        !source_reg[1] && !host_in.ctrl_write
        |=> !source_reg[1])
        else $error("flag set without hardware event");

    a_one_keeps_clear: assert property ( // RULE4
        @(posedge clk_in) disable iff (!nrst_in)
        source_reg == '0 && src_set == '0
        |=> source_reg == '0)
        else $error("software write set a source flag");

    a_ctrl_sent_set: assert property ( // RULE4
        @(posedge clk_in) disable iff (!nrst_in)
        host_in.ctrl_write
        |=> source_reg[1])
        else $error("ctrl-sent flag not set");

    a_status_taken_set: assert property ( // RULE4
        @(posedge clk_in) disable iff (!nrst_in)
        host_in.status_read
        |=> source_reg[2])
        else $error("status-taken flag not set");

    a_data_taken_set: assert property ( // RULE4
        @(posedge clk_in) disable iff (!nrst_in)
        host_in.data_reg_read && !host_in.write_cycle
        |=> source_reg[3])
        else $error("data-taken flag not set");

    a_global_en_write: assert property ( // RULE5
        @(posedge clk_in) disable iff (!nrst_in)
        wr_hostctl
        |=> global_en_reg == $past(bus_in.wdata[0]))
        else $error("global enable write lost");

    a_irq_reset_low: assert property ( // RULE5
        @(posedge clk_in) disable iff (!nrst_in)
        $rose(nrst_in)
        |-> !host_ibuf_slave_irq_out)
        else $error("interrupt high after reset");

    a_enable_reset_zero: assert property ( // RULE6
        @(posedge clk_in) disable iff (!nrst_in)
        $rose(nrst_in)
        |-> enable_reg == 8'h00)
        else $error("enable register not zero after reset");

    a_rsvd_bits_rw: assert property ( // RULE6
        @(posedge clk_in) disable iff (!nrst_in)
        wr_enable
        |=> enable_reg[7:5] == $past(bus_in.wdata[7:5]))
        else $error("reserved enable bits not stored");

    a_data_sent_gate: assert property ( // RULE7
        @(posedge clk_in) disable iff (!nrst_in)
        source_next[4] && enable_reg[4] && global_en_reg
        |=> host_ibuf_slave_irq_out)
        else $error("data-sent interrupt missing");

    a_data_taken_gate: assert property ( // RULE8
        @(posedge clk_in) disable iff (!nrst_in)
        source_next[3] && enable_reg[3] && global_en_reg
        |=> host_ibuf_slave_irq_out)
        else $error("data-taken interrupt missing");

    a_status_gate: assert property ( // RULE9
        @(posedge clk_in) disable iff (!nrst_in)
        source_next[2] && enable_reg[2] && global_en_reg
        |=> host_ibuf_slave_irq_out)
        else $error("status-taken interrupt missing");

    a_ctrl_gate: assert property ( // RULE10
        @(posedge clk_in) disable iff (!nrst_in)
        source_next[1] && enable_reg[1] && global_en_reg
        |=> host_ibuf_slave_irq_out)
        else $error("ctrl-sent interrupt missing");

    a_xfer_start_gate: assert property ( // RULE11
        @(posedge clk_in) disable iff (!nrst_in)
        source_next[0] && enable_reg[0] && global_en_reg
        |=> host_ibuf_slave_irq_out)
        else $error("transfer-start interrupt not gated through");

    a_enable_write_only: assert property ( // RULE12
        @(posedge clk_in) disable iff (!nrst_in)
        !wr_enable
        |=> $stable(enable_reg))
        else $error("enable register changed without slave write");

    a_enable_readback: assert property ( // RULE12
        @(posedge clk_in) disable iff (!nrst_in)
        bus_in.rd && sel_enable
        |=> rdata_out == $past(enable_reg))
        else $error("enable read data wrong");

    a_busy_host_only: assert property ( // RULE13
        @(posedge clk_in) disable iff (!nrst_in)
        !busy_reg && !host_in.busy_set
        |=> !busy_reg)
        else $error("busy set without host write");

    a_busy_sets: assert property ( // RULE13
        @(posedge clk_in) disable iff (!nrst_in)
        host_in.busy_set
        |=> busy_reg)
        else $error("host write did not set busy");

    a_busy_clear_read: assert property ( // RULE13
        @(posedge clk_in) disable iff (!nrst_in)
        busy_reg && !busy_armed_reg
        |=> busy_reg)
        else $error("busy cleared without prior read");

    a_busy_clears: assert property ( // RULE13
        @(posedge clk_in) disable iff (!nrst_in)
        busy_armed_reg && wr_flag && !bus_in.wdata[0] && !host_in.busy_set
        |=> !busy_reg)
        else $error("busy not cleared after read and zero write");

    a_flag_readback: assert property ( // RULE13
        @(posedge clk_in) disable iff (!nrst_in)
        rd_flag
        |=> rdata_out == {7'h00, $past(busy_reg)})
        else $error("busy read data wrong");

    a_data_sent_set: assert property ( // RULE14
        @(posedge clk_in) disable iff (!nrst_in)
        host_in.data_reg_write && host_in.write_cycle
        |=> source_reg[4])
        else $error("data-sent flag not set");

    a_masked_quiet: assert property ( // RULE7 RULE15
        @(posedge clk_in) disable iff (!nrst_in)
        (source_next & enable_reg[4:0]) == 5'h00
        |=> !host_ibuf_slave_irq_out)
        else $error("interrupt with no enabled source");

    // main scenarios
    c_xfer_irq: cover property (@(posedge clk_in) disable iff (!nrst_in)
        busy_rise ##1 host_ibuf_slave_irq_out);
    c_read_clear: cover property (@(posedge clk_in) disable iff (!nrst_in)
        rd_source && source_reg[0] ##1 wr_source && !bus_in.wdata[0]);
    c_set_on_clear: cover property (@(posedge clk_in) disable iff (!nrst_in)
        armed_reg[4] && wr_source && src_set[4]);
    c_data_sent_flag: cover property (@(posedge clk_in) disable iff (!nrst_in)
        host_in.data_reg_write && host_in.write_cycle ##1 source_reg[4]);
    c_busy_cleared: cover property (@(posedge clk_in) disable iff (!nrst_in)
        busy_armed_reg && busy_clr);
endmodule : smsirq_top

/* File: test/smsirq_host_model.sv */
// host processor model raising one-cycle transfer events
`timescale 1ns/100ps
module smsirq_host_model (
    // clock and event request from the bench
    input wire logic clk_in,
    input wire logic [5:0] ev_in,
    // events as seen by the slave side
    output smsirq_pkg::smsirq_host_s host_out = '0
);
    import smsirq_pkg::*;
    // busy is only ever set from here; data writes carry the write-cycle level
    always @(posedge clk_in) begin
        host_out <= smsirq_host_s'(ev_in);
    end
endmodule : smsirq_host_model

/* File: test/smsirq_top_test.sv */
// self-checking bench for the slave interrupt logic
`timescale 1ns/100ps
`include "smsirq_params.svh"
module smsirq_top_test;
    import smsirq_pkg::*;
    logic clk_in = 1'b0;
    logic nrst_in = 1'b0;
    smsirq_bus_s bus = '0;
    smsirq_host_s host;
    logic [5:0] ev = '0;
    logic [7:0] rdata;
    logic irq;
    logic rd_d = 1'b0;
    logic [7:0] exp_q[$];
    logic [7:0] v;
    integer failures = 0;
    integer checks = 0;
    integer seed = 32'h92ED;
    logic [5:0] ev_tab [0:4] = '{6'h20, 6'h01, 6'h02, 6'h04, 6'h18};
    initial forever #25 clk_in = ~clk_in;
    smsirq_host_model host_m (.clk_in(clk_in), .ev_in(ev), .host_out(host));
    smsirq_top dut (.clk_in(clk_in), .nrst_in(nrst_in), .bus_in(bus), .rdata_out(rdata),
        .host_in(host), .host_ibuf_slave_irq_out(irq));
    task automatic bad(input string m);
        failures++;
        $display("BAD %0t %s", $time, m);
    endtask : bad
    task automatic wrap_up;
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : wrap_up
    // idle cycle after each strobe so no signal is assigned twice in one step
    task automatic bus_op(input logic [3:0] a, input logic [7:0] d, input logic r);
        bus <= '{addr: a, wdata: d, wr: !r, rd: r};
        @(posedge clk_in);
        bus <= '0;
        @(posedge clk_in);
    endtask : bus_op
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        bus_op(a, d, 1'b0);
    endtask : wr
    task automatic rd(input logic [3:0] a, input logic [7:0] e);
        exp_q.push_back(e);
        bus_op(a, 8'h00, 1'b1);
    endtask : rd
    task automatic cmp_rd(input logic [7:0] e);
        checks++;
        if (rdata !== e) bad($sformatf("read %h want %h", rdata, e));
    endtask : cmp_rd
    task automatic cmp_irq(input logic e);
        repeat (3) @(posedge clk_in);
        checks++;
        if (irq !== e) bad("interrupt level wrong");
    endtask : cmp_irq
    task automatic fire(input logic [5:0] e);
        ev <= e;
        @(posedge clk_in);
        ev <= '0;
        repeat (3) @(posedge clk_in);
    endtask : fire
    // read data stand only in the cycle after the strobe
    always @(posedge clk_in) begin
        rd_d <= bus.rd;
        if (rd_d) cmp_rd(exp_q.pop_front());
    end
    initial begin
        repeat (4) @(posedge clk_in);
        nrst_in <= 1'b1;
        @(posedge clk_in);
        rd(`SMSIRQ_OFS_ENABLE, 8'h00);
        rd(`SMSIRQ_OFS_SOURCE, 8'h00);
        rd(4'hF, 8'h00);
        cmp_irq(1'b0);
        v = 8'($random(seed)) & 8'h1F;
        wr(`SMSIRQ_OFS_ENABLE, v);
        rd(`SMSIRQ_OFS_ENABLE, v);
        $display("test reset and access done");
        wr(`SMSIRQ_OFS_SOURCE, 8'hFF);
        rd(`SMSIRQ_OFS_SOURCE, 8'h00);
        wr(`SMSIRQ_OFS_HOSTCTL, 8'h01);
        rd(`SMSIRQ_OFS_HOSTCTL, 8'h01);
        fire(ev_tab[0]);
        wr(`SMSIRQ_OFS_SOURCE, 8'h00);
        rd(`SMSIRQ_OFS_SOURCE, 8'h01);
        wr(`SMSIRQ_OFS_SOURCE, 8'h00);
        rd(`SMSIRQ_OFS_SOURCE, 8'h00);
        rd(`SMSIRQ_OFS_FLAG, 8'h01);
        wr(`SMSIRQ_OFS_FLAG, 8'h00);
        $display("test clear after read done");
        for (int i = 0; i < 5; i++) begin
            wr(`SMSIRQ_OFS_ENABLE, 8'h01 << i);
            fire(ev_tab[i]);
            cmp_irq(1'b1);
            rd(`SMSIRQ_OFS_SOURCE, 8'h01 << i);
            wr(`SMSIRQ_OFS_HOSTCTL, 8'h00);
            cmp_irq(1'b0);
            wr(`SMSIRQ_OFS_HOSTCTL, 8'h01);
            wr(`SMSIRQ_OFS_ENABLE, 8'h1F ^ (8'h01 << i));
            cmp_irq(1'b0);
            wr(`SMSIRQ_OFS_SOURCE, 8'h00);
            rd(`SMSIRQ_OFS_SOURCE, 8'h00);
            rd(`SMSIRQ_OFS_FLAG, {7'h00, i == 0});
            wr(`SMSIRQ_OFS_FLAG, 8'h00);
            $display("test source %0d done", i);
        end
        wrap_up();
    end
    initial begin
        repeat (3000) @(posedge clk_in);
        bad("timeout");
        wrap_up();
    end
endmodule : smsirq_top_test
